// >>> design/risp_dev.sv
// device end: two-wire slave port of a clock module
// assumes ref_clk far faster than scl, osc_clk the 32.768 kHz oscillator,
// register contents kept by user logic through rd_addr/rd_data and wr_*
`timescale 1ns/1ps

module risp_dev #(
	parameter int TIMEOUT_OSC_CYC = risp_pkg::TIMEOUT_OSC_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic osc_clk,
	risp_if.dev bus,
	input wire logic osc_stable,
	input wire logic [7:0] rd_data,
	output logic [7:0] rd_addr,
	output logic wr_strobe,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic carry_hold,
	output logic count_run
);

	typedef enum {
		DS_IDLE,
		DS_ADDR,
		DS_ADDR_ACK,
		DS_PTR,
		DS_PTR_ACK,
		DS_WDATA,
		DS_WDATA_ACK,
		DS_RDATA,
		DS_RACK,
		DS_WAIT
	} risp_dev_state_t;

	// ************************************************
	// pin synchronisers
	// ************************************************
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic [2:0] stab_sync_reg;
	logic scl_f_reg;
	logic sda_f_reg;
	logic scl_now;
	logic sda_now;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			stab_sync_reg <= 3'h0;
			scl_f_reg <= 1'b1;
			sda_f_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
			sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
			stab_sync_reg <= {stab_sync_reg[1:0], osc_stable};
			scl_f_reg <= scl_now;
			sda_f_reg <= sda_now;
		end
	end

	// a change counts once the last two stages agree
	assign scl_now = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
	assign sda_now = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
	assign scl_rise = scl_now & ~scl_f_reg;
	assign scl_fall = ~scl_now & scl_f_reg;
	assign start_det = scl_now & scl_f_reg & ~sda_now & sda_f_reg;
	assign stop_det = scl_now & scl_f_reg & sda_now & ~sda_f_reg;

	// ************************************************
	// timeout crossing back from oscillator domain
	// ************************************************
	logic to_tgl_reg;
	logic [2:0] to_sync_reg;
	logic to_event;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			to_sync_reg <= 3'h0;
		end else begin
			to_sync_reg <= {to_sync_reg[1:0], to_tgl_reg};
		end
	end

	assign to_event = to_sync_reg[2] ^ to_sync_reg[1];

	// ************************************************
	// byte engine
	// ************************************************
	risp_dev_state_t state_reg;
	logic [7:0] shift_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic [3:0] cnt_reg;
	logic rw_reg;
	logic mack_reg;
	logic txn_reg;
	logic sda_oe_n_reg;
	logic addr_hit;
	logic load_rd;
	logic byte_done;

	assign addr_hit = (shift_reg[7:1] == risp_pkg::DEV_ADDR);
	assign load_rd = (state_reg == DS_ADDR_ACK) ? rw_reg : mack_reg;
	assign byte_done = scl_fall && (cnt_reg == 4'h8);
	assign bus.d_sda_out = 1'b0;
	assign bus.d_sda_oe_n = sda_oe_n_reg;
	assign rd_addr = ptr_reg;
	assign carry_hold = txn_reg;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= DS_IDLE;
			shift_reg <= 8'h00;
			tx_reg <= 8'hFF;
			ptr_reg <= risp_pkg::PTR_RST;
			cnt_reg <= 4'h0;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
			txn_reg <= 1'b0;
			sda_oe_n_reg <= 1'b1;
			wr_strobe <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
		end else begin
			wr_strobe <= 1'b0;
			if (start_det) begin
				// restart keeps txn_reg high so the timeout keeps running
				state_reg <= DS_ADDR;
				cnt_reg <= 4'h0;
				sda_oe_n_reg <= 1'b1;
				txn_reg <= 1'b1;
			end else if (stop_det) begin
				state_reg <= DS_IDLE;
				sda_oe_n_reg <= 1'b1;
				txn_reg <= 1'b0;
			end else if (to_event && txn_reg) begin
				// nothing more is acked, so writes drop and reads float high
				state_reg <= DS_IDLE;
				sda_oe_n_reg <= 1'b1;
				txn_reg <= 1'b0;
			end else begin
				case (state_reg)
					DS_ADDR, DS_PTR, DS_WDATA: begin
						if (scl_rise) begin
							shift_reg <= {shift_reg[6:0], sda_now};
							cnt_reg <= cnt_reg + 4'h1;
						end
						if (byte_done) begin
							cnt_reg <= 4'h0;
							sda_oe_n_reg <= 1'b0;
							if (state_reg == DS_ADDR) begin
								if (addr_hit) begin
									rw_reg <= shift_reg[0];
									state_reg <= DS_ADDR_ACK;
								end else begin
									sda_oe_n_reg <= 1'b1;
									txn_reg <= 1'b0;
									state_reg <= DS_IDLE;
								end
							end else if (state_reg == DS_PTR) begin
								ptr_reg <= shift_reg;
								state_reg <= DS_PTR_ACK;
							end else begin
								wr_strobe <= 1'b1;
								wr_addr <= ptr_reg;
								wr_data <= shift_reg;
								ptr_reg <= ptr_reg + 8'h01;
								state_reg <= DS_WDATA_ACK;
							end
						end
					end
					DS_PTR_ACK, DS_WDATA_ACK: begin
						if (scl_fall) begin
							sda_oe_n_reg <= 1'b1;
							cnt_reg <= 4'h0;
							state_reg <= DS_WDATA;
						end
					end
					DS_ADDR_ACK, DS_RACK: begin
						if (scl_rise) begin
							mack_reg <= ~sda_now;
						end
						if (scl_fall) begin
							cnt_reg <= 4'h0;
							if (load_rd) begin
								// pointer is whatever was last set or reached
								tx_reg <= {rd_data[6:0], 1'b1};
								sda_oe_n_reg <= rd_data[7];
								ptr_reg <= ptr_reg + 8'h01;
								state_reg <= DS_RDATA;
							end else if (state_reg == DS_ADDR_ACK) begin
								sda_oe_n_reg <= 1'b1;
								state_reg <= DS_PTR;
							end else begin
								sda_oe_n_reg <= 1'b1;
								state_reg <= DS_WAIT;
							end
						end
					end
					DS_RDATA: begin
						if (scl_fall) begin
							if (cnt_reg == 4'h7) begin
								sda_oe_n_reg <= 1'b1;
								state_reg <= DS_RACK;
							end else begin
								sda_oe_n_reg <= tx_reg[7];
								tx_reg <= {tx_reg[6:0], 1'b1};
								cnt_reg <= cnt_reg + 4'h1;
							end
						end
					end
					DS_WAIT: begin
						sda_oe_n_reg <= 1'b1;
					end
					DS_IDLE: begin
						sda_oe_n_reg <= 1'b1;
					end
					default: begin
						state_reg <= DS_IDLE;
					end
				endcase
			end
		end
	end

	// ************************************************
	// timekeeping enables
	// ************************************************
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_run <= 1'b0;
		end else if (stab_sync_reg[1] == stab_sync_reg[2]) begin
			// counting never waits on the bus, only on the oscillator
			count_run <= stab_sync_reg[2];
		end
	end

	// ************************************************
	// bus timeout in oscillator domain
	// ************************************************
	logic [1:0] txn_sync_reg;
	logic [16:0] to_cnt_reg;
	logic to_at_limit;
	logic to_fire;

	assign to_at_limit = (to_cnt_reg == 17'(TIMEOUT_OSC_CYC));
	assign to_fire = (to_cnt_reg == 17'(TIMEOUT_OSC_CYC - 1));

	always_ff @(posedge osc_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txn_sync_reg <= 2'h0;
			to_cnt_reg <= 17'h00000;
			to_tgl_reg <= 1'b0;
		end else begin
			txn_sync_reg <= {txn_sync_reg[0], txn_reg};
			if (!txn_sync_reg[1]) begin
				to_cnt_reg <= 17'h00000;
			end else if (!to_at_limit) begin
				to_cnt_reg <= to_cnt_reg + 17'h00001;
				if (to_fire) begin
					to_tgl_reg <= ~to_tgl_reg;
				end
			end
		end
	end

endmodule

// >>> design/risp_host.sv
// host end: two-wire bus master, one bus action per command
// assumes the device samples fast enough for the chosen scl rate
`timescale 1ns/1ps
module risp_host #(
	parameter int POWERUP_WAIT_CYC = risp_pkg::POWERUP_WAIT_CYC,
	parameter int TXN_LIMIT_CYC = risp_pkg::TXN_LIMIT_CYC,
	parameter int QTR_CYC = risp_pkg::QTR_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	risp_if.host bus,
	input wire logic cmd_valid,
	input wire risp_pkg::risp_cmd_t cmd_code,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_ack,
	output logic txn_overtime,
	output logic first_txn
);

	typedef enum {
		HS_WAIT,
		HS_IDLE,
		HS_RUN
	} risp_host_state_t;

	// ************************************************
	// sda sampling and quarter-bit divider
	// ************************************************
	logic [2:0] sda_sync_reg;
	logic sda_f_reg;
	logic sda_now;
	logic [15:0] qcnt_reg;
	logic qtick;

	assign sda_now = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
	assign qtick = (qcnt_reg == 16'(QTR_CYC - 1));

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sda_sync_reg <= 3'h7;
			sda_f_reg <= 1'b1;
			qcnt_reg <= 16'h0000;
		end else begin
			sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
			sda_f_reg <= sda_now;
			qcnt_reg <= qtick ? 16'h0000 : qcnt_reg + 16'h0001;
		end
	end

	// ************************************************
	// bit sequencer
	// ************************************************
	risp_host_state_t state_reg;
	risp_pkg::risp_cmd_t op_reg;
	logic [1:0] phase_reg;
	logic [3:0] bitn_reg;
	logic [7:0] sh_reg;
	logic [22:0] wait_reg;
	logic [27:0] txn_cnt_reg;
	logic txn_open_reg;
	logic scl_oe_n_reg;
	logic sda_oe_n_reg;
	logic is_byte;
	logic out_bit;
	logic last_q;

	assign is_byte = (op_reg != risp_pkg::RISP_CMD_START) && (op_reg != risp_pkg::RISP_CMD_STOP);
	assign out_bit = (bitn_reg == 4'h8) ? (op_reg != risp_pkg::RISP_CMD_READ_ACK) :
		((op_reg == risp_pkg::RISP_CMD_WRITE) ? sh_reg[7] : 1'b1);
	assign last_q = qtick && (phase_reg == 2'h3) && (!is_byte || bitn_reg == 4'h8);
	assign bus.scl_out = 1'b0;
	assign bus.h_sda_out = 1'b0;
	assign bus.scl_oe_n = scl_oe_n_reg;
	assign bus.h_sda_oe_n = sda_oe_n_reg;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= HS_WAIT;
			op_reg <= risp_pkg::RISP_CMD_STOP;
			phase_reg <= 2'h0;
			bitn_reg <= 4'h0;
			sh_reg <= 8'h00;
			wait_reg <= 23'h000000;
			scl_oe_n_reg <= 1'b1;
			sda_oe_n_reg <= 1'b1;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_ack <= 1'b0;
			first_txn <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			case (state_reg)
				HS_WAIT: begin
					// no bus access until supply has settled
					wait_reg <= wait_reg + 23'h000001;
					if (wait_reg == 23'(POWERUP_WAIT_CYC - 1)) begin
						state_reg <= HS_IDLE;
						cmd_ready <= 1'b1;
						first_txn <= 1'b1;
					end
				end
				HS_IDLE: begin
					if (cmd_valid && cmd_ready && qtick) begin
						op_reg <= cmd_code;
						sh_reg <= cmd_wdata;
						phase_reg <= 2'h0;
						bitn_reg <= 4'h0;
						cmd_ready <= 1'b0;
						state_reg <= HS_RUN;
					end
				end
				HS_RUN: begin
					if (qtick) begin
						phase_reg <= phase_reg + 2'h1;
						case (phase_reg)
							2'h0: sda_oe_n_reg <= (op_reg == risp_pkg::RISP_CMD_START) ? 1'b1 :
								((op_reg == risp_pkg::RISP_CMD_STOP) ? 1'b0 : out_bit);
							2'h1: scl_oe_n_reg <= 1'b1;
							2'h2: begin
								if (op_reg == risp_pkg::RISP_CMD_START) begin
									sda_oe_n_reg <= 1'b0;
								end else if (op_reg == risp_pkg::RISP_CMD_STOP) begin
									sda_oe_n_reg <= 1'b1;
								end else if (bitn_reg == 4'h8) begin
									rsp_ack <= ~sda_now;
								end else begin
									sh_reg <= {sh_reg[6:0], sda_now};
								end
							end
							default: begin
								if (op_reg != risp_pkg::RISP_CMD_STOP) begin
									scl_oe_n_reg <= 1'b0;
								end
								bitn_reg <= bitn_reg + 4'h1;
							end
						endcase
						if (last_q) begin
							state_reg <= HS_IDLE;
							cmd_ready <= 1'b1;
							rsp_valid <= 1'b1;
							rsp_data <= sh_reg;
							if (op_reg == risp_pkg::RISP_CMD_STOP) begin
								first_txn <= 1'b0;
							end
						end
					end
				end
				default: begin
					state_reg <= HS_IDLE;
				end
			endcase
		end
	end

	// ************************************************
	// transaction length watch
	// ************************************************
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txn_open_reg <= 1'b0;
			txn_cnt_reg <= 28'h0000000;
			txn_overtime <= 1'b0;
		end else begin
			if (last_q && op_reg == risp_pkg::RISP_CMD_START && !txn_open_reg) begin
				txn_open_reg <= 1'b1;
				txn_cnt_reg <= 28'h0000000;
				txn_overtime <= 1'b0;
			end else if (last_q && op_reg == risp_pkg::RISP_CMD_STOP) begin
				txn_open_reg <= 1'b0;
			end else if (txn_open_reg && !txn_overtime) begin
				txn_cnt_reg <= txn_cnt_reg + 28'h0000001;
				if (txn_cnt_reg == 28'(TXN_LIMIT_CYC - 1)) begin
					txn_overtime <= 1'b1;
				end
			end
		end
	end

endmodule

// >>> design/risp_if.sv
// open-drain two-wire link between host end and device end
// assumes pull-ups: a released line reads high
`timescale 1ns/1ps
interface risp_if;
	logic scl_out;
	logic scl_oe_n;
	logic h_sda_out;
	logic h_sda_oe_n;
	logic d_sda_out;
	logic d_sda_oe_n;
	logic scl;
	logic sda;

	// wired-and of both sda drivers; scl is driven by the host alone
	assign scl = scl_oe_n | scl_out;
	assign sda = (h_sda_oe_n | h_sda_out) & (d_sda_oe_n | d_sda_out);

	modport host (
		output scl_out,
		output scl_oe_n,
		output h_sda_out,
		output h_sda_oe_n,
		input scl,
		input sda
	);

	modport dev (
		output d_sda_out,
		output d_sda_oe_n,
		input scl,
		input sda
	);
endinterface

// >>> design/risp_pkg.sv
// shared constants and types of the two-wire clock-module port
// assumes a 200 MHz ref_clk at both ends and a 32.768 kHz oscillator at the device
package risp_pkg;

	// ************************************************
	// bus addressing
	// ************************************************
	localparam logic [6:0] DEV_ADDR = 7'h32;
	localparam logic [7:0] PTR_RST = 8'h00;

	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int OSC_HZ = 32768;
	localparam int TIMEOUT_S = 1;
	localparam int TIMEOUT_OSC_CYC = TIMEOUT_S * OSC_HZ;
	localparam int POWERUP_WAIT_MS = 30;
	localparam int POWERUP_WAIT_CYC = POWERUP_WAIT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TXN_LIMIT_MS = 1000;
	localparam int TXN_LIMIT_CYC = TXN_LIMIT_MS * 1000000 / CLK_PERIOD_NS;

	// ************************************************
	// host commands
	// ************************************************
	typedef enum logic [2:0] {
		RISP_CMD_START,
		RISP_CMD_STOP,
		RISP_CMD_WRITE,
		RISP_CMD_READ_ACK,
		RISP_CMD_READ_NACK
	} risp_cmd_t;

endpackage

// >>> test/risp_chk.sv
// checker of the two-wire link between host end and device end
// assumes osc_clk is 32 ref_clk cycles long
`timescale 1ns/1ps
module risp_chk #(
	parameter int TIMEOUT_OSC_CYC = 64
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic d_sda_oe_n,
	input wire logic carry_hold,
	input wire logic count_run,
	input wire logic osc_stable,
	input wire logic wr_strobe
);
	// ********
	// helpers
	// ********
	localparam int TO_MAX = TIMEOUT_OSC_CYC * 64;
	logic [7:0] lo_cnt_reg;
	logic [15:0] hold_cnt_reg;
	wire logic lo_sat = lo_cnt_reg == 8'hFF;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// cycles since scl fell, and since the transaction opened
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lo_cnt_reg <= 8'h00;
			hold_cnt_reg <= 16'h0000;
		end else begin
			lo_cnt_reg <= scl ? 8'h00 : lo_cnt_reg + {7'h00, !lo_sat};
			hold_cnt_reg <= carry_hold ? hold_cnt_reg + 16'h0001 : 16'h0000;
		end
	end

	// ********
	// rules
	// ********
	AST_DEV_SDA_SCL_LOW: assert property ($changed(d_sda_oe_n) |-> !scl)
		else $error("device sda moved with scl high");
	AST_DEV_PULL_PROMPT: assert property ($fell(d_sda_oe_n) |-> lo_cnt_reg < 8'h0C)
		else $error("device pull late after scl fall");
	AST_DEV_RELEASE_PROMPT: assert property ($rose(d_sda_oe_n) && carry_hold |-> lo_cnt_reg < 8'h0C)
		else $error("device release late after scl fall");
	AST_DEV_PULL_IN_TXN: assert property (!d_sda_oe_n |-> $past(carry_hold))
		else $error("device pulls sda outside a transaction");
	AST_START_HOLDS: assert property ($fell(sda) && scl |-> ##[1:8] carry_hold)
		else $error("start did not freeze carries");
	AST_STOP_ENDS: assert property ($rose(sda) && scl |-> ##[1:8] !carry_hold)
		else $error("stop did not end transaction");
	AST_TIMEOUT_BOUND: assert property (carry_hold |-> hold_cnt_reg <= TO_MAX)
		else $error("transaction outlived the timeout");
	AST_WR_IN_TXN: assert property (wr_strobe |-> carry_hold)
		else $error("write outside a transaction");
	AST_COUNT_WAITS: assert property (!osc_stable |-> !count_run)
		else $error("counting before oscillator stable");
endmodule

// >>> test/tb_top.sv
// self-checking bench: host end and device end joined by the link
// assumes shortened timeout, power-up wait and quarter counts
`timescale 1ns/1ps
module tb_top;
	// ********
	// setup
	// ********
	localparam int TO = 64;
	localparam risp_pkg::risp_cmd_t CS = risp_pkg::RISP_CMD_START;
	localparam risp_pkg::risp_cmd_t CP = risp_pkg::RISP_CMD_STOP;
	logic ref_clk = 1'b0;
	logic osc_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic osc_stable = 1'b0;
	logic cmd_valid = 1'b0;
	risp_pkg::risp_cmd_t cmd_code = CP;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_ready, rsp_valid, rsp_ack, wr_strobe, carry_hold, count_run;
	logic [7:0] rsp_data, rd_addr, rd_data, wr_addr, wr_data;
	logic txn_overtime, first_txn;
	logic [7:0] mem [256];
	logic [15:0] wq [$];
	logic [7:0] wd [3] = '{8'h5A, 8'hA5, 8'hC3};
	logic [7:0] bad [4] = '{8'h66, 8'hE4, 8'h24, 8'h67};
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	risp_if bus();

	always #2.5 ref_clk = ~ref_clk;
	initial #37 forever #80 osc_clk = ~osc_clk;

	// register file of the clock module
	assign rd_data = mem[rd_addr];
	always @(posedge ref_clk) begin
		if (wr_strobe === 1'b1) begin
			mem[wr_addr] <= wr_data;
			wq.push_back({wr_addr, wr_data});
		end
	end

	risp_host #(.POWERUP_WAIT_CYC(20), .TXN_LIMIT_CYC(5000), .QTR_CYC(8)) i_risp_host (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_ack(rsp_ack), .txn_overtime(txn_overtime), .first_txn(first_txn));
	risp_dev #(.TIMEOUT_OSC_CYC(TO)) i_risp_dev (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .osc_clk(osc_clk), .bus(bus),
		.osc_stable(osc_stable), .rd_data(rd_data), .rd_addr(rd_addr), .wr_strobe(wr_strobe),
		.wr_addr(wr_addr), .wr_data(wr_data), .carry_hold(carry_hold), .count_run(count_run));
	risp_chk #(.TIMEOUT_OSC_CYC(TO)) i_risp_chk (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .scl(bus.scl), .sda(bus.sda),
		.d_sda_oe_n(bus.d_sda_oe_n), .carry_hold(carry_hold), .count_run(count_run),
		.osc_stable(osc_stable), .wr_strobe(wr_strobe));

	// ********
	// tasks
	// ********
	task automatic conclude();
		$display("errors %0d checks %0d", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
			fail_count++;
		end
	endtask

	// one host command: hold valid until taken, then await response
	task automatic cmd(input risp_pkg::risp_cmd_t c, input logic [7:0] d);
		while (cmd_ready !== 1'b1) @(negedge ref_clk);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_wdata <= d;
		while (cmd_ready !== 1'b0) @(negedge ref_clk);
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		while (rsp_valid !== 1'b1) @(negedge ref_clk);
	endtask

	task automatic wrb(input logic [7:0] d, input logic a);
		cmd(risp_pkg::RISP_CMD_WRITE, d);
		chk("ack", {7'h00, a}, {7'h00, rsp_ack});
	endtask

	task automatic rdb(input logic last, input logic [7:0] e);
		cmd(last ? risp_pkg::RISP_CMD_READ_NACK : risp_pkg::RISP_CMD_READ_ACK, 8'h00);
		chk("rdata", e, rsp_data);
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			$display("CHECK FAILED watchdog exp done got hang");
			conclude();
		end
	end

	// ********
	// sequence
	// ********
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h3C;
		repeat (12) @(posedge ref_clk);
		chk("rst ready", 8'h00, {7'h00, cmd_ready});
		chk("rst sda", 8'h01, {7'h00, bus.sda});
		sys_rst <= 1'b0;
		repeat (200) @(posedge ref_clk);
		chk("count run", 8'h00, {7'h00, count_run});
		osc_stable <= 1'b1;
		repeat (300) @(posedge ref_clk);
		chk("count run", 8'h01, {7'h00, count_run});
		chk("first txn", 8'h01, {7'h00, first_txn});
		// pointer write then three stored bytes
		cmd(CS, 8'h00);
		wrb(8'h64, 1'b1);
		wrb(8'h10, 1'b1);
		foreach (wd[i]) wrb(wd[i], 1'b1);
		cmd(CP, 8'h00);
		repeat (4) @(posedge ref_clk);
		chk("writes", 8'h03, 8'(wq.size()));
		chk("first txn", 8'h00, {7'h00, first_txn});
		chk("overtime", 8'h00, {7'h00, txn_overtime});
		foreach (wd[i]) begin
			chk("wr addr", 8'h10 + 8'(i), wq[i][15:8]);
			chk("wr data", wd[i], wq[i][7:0]);
		end
		// random read through a restart
		cmd(CS, 8'h00);
		wrb(8'h64, 1'b1);
		wrb(8'h11, 1'b1);
		cmd(CS, 8'h00);
		wrb(8'h65, 1'b1);
		rdb(1'b0, 8'hA5);
		rdb(1'b1, 8'hC3);
		cmd(CP, 8'h00);
		// plain read continues after last byte
		cmd(CS, 8'h00);
		wrb(8'h65, 1'b1);
		rdb(1'b1, 8'h13 ^ 8'h3C);
		cmd(CP, 8'h00);
		foreach (bad[i]) begin
			cmd(CS, 8'h00);
			wrb(bad[i], 1'b0);
			wrb(8'h01, 1'b0);
			cmd(CP, 8'h00);
		end
		chk("writes", 8'h03, 8'(wq.size()));
		// stalled write past the timeout
		cmd(CS, 8'h00);
		wrb(8'h64, 1'b1);
		wrb(8'h20, 1'b1);
		repeat (TO * 70) @(posedge ref_clk);
		wrb(8'h77, 1'b0);
		chk("overtime", 8'h01, {7'h00, txn_overtime});
		cmd(CP, 8'h00);
		repeat (300) @(posedge ref_clk);
		chk("writes", 8'h03, 8'(wq.size()));
		// stalled read past the timeout
		cmd(CS, 8'h00);
		wrb(8'h65, 1'b1);
		rdb(1'b0, 8'h20 ^ 8'h3C);
		repeat (TO * 70) @(posedge ref_clk);
		rdb(1'b1, 8'hFF);
		cmd(CP, 8'h00);
		repeat (300) @(posedge ref_clk);
		cmd(CS, 8'h00);
		wrb(8'h64, 1'b1);
		cmd(CP, 8'h00);
		conclude();
	end
endmodule
